// >>> rtl/ssprx_top.v
// receive half of a synchronous serial port with receive fifo
`include "ssprx_consts.vh"
`default_nettype none
// How it works
// - rx_fifo_nonempty_flag shows the fifo holds at least one word.
// - a pulse on rx_frame_sync starts reception of one word.
// - each rx_serial_in bit shifts into rx_shift_reg, msb first.
// - rx_interrupt fires when fifo word count reaches the level chosen by two bits.
// - copying rx_shift_reg into rx_data_reg raises rx_ready_flag from 0 to 1.
// - the rising edge of rx_ready_flag also raises rx_interrupt.
// - rx_ready_flag is a plain output, pollable at any time.
// - a data port read pops a word; a write goes to the transmit side.
// - rx_reset_n_bit low holds the receiver in reset; it resets to 0.
// - rx_overrun_flag sets when a word arrives with no room to take it.
module ssprx_top (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // serial pins
  input wire rx_clk_i,
  input wire rx_frame_sync_i,
  input wire rx_serial_in_i,
  // control bits
  input wire rx_reset_n_bit_i,
  input wire rx_reset_n_bit_we_i,
  input wire rx_irq_level_hi_bit_i,
  input wire rx_irq_level_lo_bit_i,
  input wire rx_use_fifo_i,
  input wire rx_overrun_clr_i,
  // data port
  input wire data_port_rd_i,
  input wire data_port_wr_i,
  input wire [15:0] data_port_wdata_i,
  // status and data out
  output reg [15:0] data_port_rdata_o,
  output reg data_port_rvalid_o,
  output reg tx_wr_o,
  output reg [15:0] tx_wdata_o,
  output reg rx_ready_flag_o,
  output reg rx_fifo_nonempty_flag_o,
  output reg rx_overrun_flag_o,
  output reg rx_interrupt_o,
  output reg rx_reset_n_bit_o
);
  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  reg [1:0] rst_sync;
  wire rst_n;
  wire [2:0] pin_raw;
  wire [2:0] pin_sync;
  reg sclk_d;
  wire sclk_rise;
  wire fs_now;
  wire din;

  // two-stage reset release
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1]; // rest of the block uses this copy

  // pins in a fixed order: bit clock, frame sync, data
  assign pin_raw = {rx_clk_i, rx_frame_sync_i, rx_serial_in_i};

  // each pin passes two flops before any logic reads it
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin_sync
      reg [1:0] stage;
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          stage <= 2'h0;
        end else begin
          stage <= {stage[0], pin_raw[g]};
        end
      end
      assign pin_sync[g] = stage[1];
    end
  endgenerate

  // third flop on the bit clock feeds only its edge detect
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0; // idle level of the bit clock, so no false edge
    end else begin
      sclk_d <= pin_sync[2];
    end
  end

  // synchronised views of the three pins
  assign sclk_rise = pin_sync[2] & ~sclk_d;
  assign fs_now = pin_sync[1];
  assign din = pin_sync[0];

  // ------------------------------------------------------------
  // receiver reset bit
  // ------------------------------------------------------------
  reg rx_reset_n_bit;

  // software writes the bit; device reset clears it
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_reset_n_bit <= 1'b0;
    end else if (rx_reset_n_bit_we_i) begin
      rx_reset_n_bit <= rx_reset_n_bit_i;
    end
  end

  // ------------------------------------------------------------
  // shifter
  // ------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;
  reg state;
  reg next_state;
  reg [15:0] rx_shift_reg;
  reg [3:0] bit_cnt;
  reg word_done;
  reg [15:0] rx_data_reg;
  reg rx_ready_flag;
  reg rx_overrun_flag;

  // true on the count that belongs to the final bit of a word
  function last_bit;
    input [3:0] cnt;
    begin
      last_bit = (cnt == `SSPRX_LAST_BIT);
    end
  endfunction

  // next state: frame sync starts a word, last bit ends it
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sclk_rise & fs_now) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sclk_rise & last_bit(bit_cnt)) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // shift register; first bit is sampled with the sync pulse
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      rx_shift_reg <= `SSPRX_WORD_RESET;
      bit_cnt <= `SSPRX_CNT_RESET;
      word_done <= 1'b0;
    end else if (!rx_reset_n_bit) begin
      state <= ST_IDLE;
      bit_cnt <= `SSPRX_CNT_RESET;
      word_done <= 1'b0;
    end else begin
      state <= next_state;
      word_done <= 1'b0;
      if (sclk_rise & ((state == ST_SHIFT) | fs_now)) begin
        rx_shift_reg <= {rx_shift_reg[14:0], din};
        if (state == ST_IDLE) begin
          bit_cnt <= `SSPRX_CNT_FIRST; // first bit came with the sync
        end else begin
          bit_cnt <= bit_cnt + 4'h0001;
        end
        word_done <= (state == ST_SHIFT) & last_bit(bit_cnt);
      end
    end
  end

  // ------------------------------------------------------------
  // receive fifo
  // ------------------------------------------------------------
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire [5:0] fifo_count;
  wire fifo_push;
  wire fifo_pop;
  wire drr_pop;

  // words go to the fifo or to the data register, by mode
  assign fifo_push = word_done & rx_use_fifo_i;
  assign fifo_pop = data_port_rd_i & rx_use_fifo_i;
  assign drr_pop = data_port_rd_i & ~rx_use_fifo_i;

  // receive buffer, flushed while the receiver is held
  ssprx_fifo #(
    .WIDTH(`SSPRX_WORD_BITS),
    .DEPTH(`SSPRX_FIFO_DEPTH),
    .AW(`SSPRX_FIFO_AW)
  ) ssprx_fifo_inst (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .flush_i(~rx_reset_n_bit),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_shift_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data),
    .count_o(fifo_count)
  );

  // ------------------------------------------------------------
  // data register, ready and overrun flags
  // ------------------------------------------------------------
  wire reg_overrun;
  wire fifo_overrun;

  // a word lands on an unread register, or finds the fifo full
  assign reg_overrun = word_done & ~rx_use_fifo_i & rx_ready_flag & ~drr_pop;
  assign fifo_overrun = fifo_push & ~fifo_in_ready;

  // word copy to rx_data_reg when not in fifo mode; set wins over clear
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_reg <= `SSPRX_WORD_RESET;
      rx_ready_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
    end else if (!rx_reset_n_bit) begin
      rx_ready_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
    end else begin
      if (word_done & ~rx_use_fifo_i) begin
        rx_data_reg <= rx_shift_reg;
        rx_ready_flag <= 1'b1;
      end else if (drr_pop) begin
        rx_ready_flag <= 1'b0;
      end
      if (reg_overrun | fifo_overrun) begin
        rx_overrun_flag <= 1'b1;
      end else if (rx_overrun_clr_i) begin
        rx_overrun_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt and outputs
  // ------------------------------------------------------------
  reg ready_d;
  reg level_hit_d;
  reg [5:0] irq_level;
  wire level_hit;
  wire ready_rise;
  wire level_rise;

  // trigger level from the two level bits
  always @* begin
    case ({rx_irq_level_hi_bit_i, rx_irq_level_lo_bit_i})
      2'h0: irq_level = `SSPRX_LVL_1;
      2'h1: irq_level = `SSPRX_LVL_2;
      2'h2: irq_level = `SSPRX_LVL_3;
      2'h3: irq_level = `SSPRX_LVL_4;
      default: irq_level = `SSPRX_LVL_1;
    endcase
  end
  // the fill level only counts in fifo mode
  assign level_hit = rx_use_fifo_i & (fifo_count >= irq_level);

  // one-cycle events: ready flag rising, level first reached
  assign ready_rise = rx_ready_flag & ~ready_d;
  assign level_rise = level_hit & ~level_hit_d;

  // registered outputs; interrupt is a one-cycle pulse
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ready_d <= 1'b0;
      level_hit_d <= 1'b0;
      rx_interrupt_o <= 1'b0;
      rx_ready_flag_o <= 1'b0;
      rx_fifo_nonempty_flag_o <= 1'b0;
      rx_overrun_flag_o <= 1'b0;
      rx_reset_n_bit_o <= 1'b0;
      data_port_rdata_o <= `SSPRX_WORD_RESET;
      data_port_rvalid_o <= 1'b0;
      tx_wr_o <= 1'b0;
      tx_wdata_o <= `SSPRX_WORD_RESET;
    end else begin
      ready_d <= rx_ready_flag;
      level_hit_d <= level_hit;
      rx_interrupt_o <= ready_rise | level_rise;
      rx_ready_flag_o <= rx_ready_flag;
      rx_fifo_nonempty_flag_o <= fifo_out_valid;
      rx_overrun_flag_o <= rx_overrun_flag;
      rx_reset_n_bit_o <= rx_reset_n_bit;
      data_port_rvalid_o <= data_port_rd_i;
      if (data_port_rd_i) begin
        data_port_rdata_o <= rx_use_fifo_i ? fifo_out_data : rx_data_reg;
      end
      tx_wr_o <= data_port_wr_i;
      if (data_port_wr_i) begin
        tx_wdata_o <= data_port_wdata_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ssprx_consts.vh
// constants for the synchronous serial port receiver
`ifndef SSPRX_CONSTS_VH
`define SSPRX_CONSTS_VH
`define SSPRX_WORD_BITS 16
`define SSPRX_CNT_BITS 4
`define SSPRX_FIFO_DEPTH 32
`define SSPRX_FIFO_AW 5
`define SSPRX_FIFO_CW 6
`define SSPRX_LAST_BIT 4'h000f
`define SSPRX_CNT_RESET 4'h0000
`define SSPRX_CNT_FIRST 4'h0001
`define SSPRX_WORD_RESET 16'h0000
`define SSPRX_LVL_1 6'h0001
`define SSPRX_LVL_2 6'h0002
`define SSPRX_LVL_3 6'h0003
`define SSPRX_LVL_4 6'h0004
`endif

// >>> rtl/ssprx_fifo.v
// parameterised fifo with valid and ready on both sides
`default_nettype none
module ssprx_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  input wire flush_i,
  // write side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // read side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // fill level
  output wire [AW:0] count_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // handshakes and honest flags
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];
  assign count_o = count;

  // storage
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and count
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/ssprx_top_sva.sv
// port assertions for the synchronous serial receiver
`default_nettype none
module ssprx_top_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // watched inputs
  input wire logic rx_reset_n_bit_i,
  input wire logic rx_reset_n_bit_we_i,
  input wire logic rx_use_fifo_i,
  input wire logic data_port_rd_i,
  input wire logic data_port_wr_i,
  input wire logic [15:0] data_port_wdata_i,
  // watched outputs
  input wire logic data_port_rvalid_o,
  input wire logic tx_wr_o,
  input wire logic [15:0] tx_wdata_o,
  input wire logic rx_ready_flag_o,
  input wire logic rx_fifo_nonempty_flag_o,
  input wire logic rx_overrun_flag_o,
  input wire logic rx_interrupt_o,
  input wire logic rx_reset_n_bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----
  // sequences
  // ----
  sequence s_rd_ready;
    data_port_rd_i && rx_ready_flag_o && !rx_use_fifo_i;
  endsequence
  sequence s_ready_up;
    $rose(rx_ready_flag_o);
  endsequence
  // ----
  // properties
  // ----
  a_read_answered: assert property (data_port_rd_i |=> data_port_rvalid_o) else $error("read unanswered");
  a_answer_has_cause: assert property (data_port_rvalid_o |-> $past(data_port_rd_i)) else $error("stray answer");
  a_tx_forwarded: assert property (data_port_wr_i |=> tx_wr_o && tx_wdata_o == $past(data_port_wdata_i))
    else $error("write not forwarded");
  a_irq_on_ready: assert property (s_ready_up |-> ##[0:1] rx_interrupt_o) else $error("no irq on ready");
  a_irq_one_cycle: assert property (rx_interrupt_o |=> !rx_interrupt_o) else $error("irq too long");
  a_ready_cleared: assert property (s_rd_ready |-> ##2 !rx_ready_flag_o) else $error("ready not cleared");
  a_bit_written: assert property (rx_reset_n_bit_we_i |-> ##2 rx_reset_n_bit_o == $past(rx_reset_n_bit_i, 2))
    else $error("reset bit not written");
  a_rx_held_idle: assert property (!rx_reset_n_bit_o [*4] |-> !rx_ready_flag_o && !rx_fifo_nonempty_flag_o
    && !rx_overrun_flag_o) else $error("flags while held");
  a_overrun_live: assert property ($rose(rx_overrun_flag_o) |-> rx_reset_n_bit_o) else $error("overrun held");
endmodule
bind ssprx_top ssprx_top_chk ssprx_top_chk_inst (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .rx_reset_n_bit_i(rx_reset_n_bit_i),
  .rx_reset_n_bit_we_i(rx_reset_n_bit_we_i),
  .rx_use_fifo_i(rx_use_fifo_i),
  .data_port_rd_i(data_port_rd_i),
  .data_port_wr_i(data_port_wr_i),
  .data_port_wdata_i(data_port_wdata_i),
  .data_port_rvalid_o(data_port_rvalid_o),
  .tx_wr_o(tx_wr_o),
  .tx_wdata_o(tx_wdata_o),
  .rx_ready_flag_o(rx_ready_flag_o),
  .rx_fifo_nonempty_flag_o(rx_fifo_nonempty_flag_o),
  .rx_overrun_flag_o(rx_overrun_flag_o),
  .rx_interrupt_o(rx_interrupt_o),
  .rx_reset_n_bit_o(rx_reset_n_bit_o)
);
`default_nettype wire

// >>> bench/ssprx_codec.sv
// serial codec model feeding words into the receiver
`default_nettype none
module ssprx_codec (
  // serial pins
  output logic rx_clk_o,
  output logic rx_frame_sync_o,
  output logic rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit clock stands still between frames
  initial begin
    rx_clk_o = 1'h0;
    rx_frame_sync_o = 1'h0;
    rx_data_o = 1'h0;
  end
  // one frame, msb first, half is the bit clock half period
  task automatic send(input logic [15:0] w, input int half);
    for (int i = 15; i >= 0; i--) begin
      rx_frame_sync_o = (i == 15);
      rx_data_o = w[i];
      #half rx_clk_o = 1'h1;
      #half rx_clk_o = 1'h0;
    end
    rx_frame_sync_o = 1'h0;
    rx_data_o = ~w[0]; // released line shows no stale bit
  endtask
endmodule
`default_nettype wire

// >>> bench/ssprx_top_tb.sv
// self-checking bench for the synchronous serial receiver
`default_nettype none
module ssprx_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
  logic clk_i, reset_n_i, rx_clk_i, rx_frame_sync_i, rx_serial_in_i;
  logic rx_reset_n_bit_i, rx_reset_n_bit_we_i, rx_irq_level_hi_bit_i, rx_irq_level_lo_bit_i;
  logic rx_use_fifo_i, rx_overrun_clr_i, data_port_rd_i, data_port_wr_i, data_port_rvalid_o, tx_wr_o;
  logic [15:0] data_port_wdata_i, data_port_rdata_o, tx_wdata_o;
  logic rx_ready_flag_o, rx_fifo_nonempty_flag_o, rx_overrun_flag_o, rx_interrupt_o, rx_reset_n_bit_o;
  int err_count = 0, comparisons = 0, irqs = 0, irq_mark = 0;
  ssprx_top ssprx_top_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .rx_clk_i(rx_clk_i), .rx_frame_sync_i(rx_frame_sync_i), .rx_serial_in_i(rx_serial_in_i),
    .rx_reset_n_bit_i(rx_reset_n_bit_i), .rx_reset_n_bit_we_i(rx_reset_n_bit_we_i),
    .rx_irq_level_hi_bit_i(rx_irq_level_hi_bit_i), .rx_irq_level_lo_bit_i(rx_irq_level_lo_bit_i),
    .rx_use_fifo_i(rx_use_fifo_i), .rx_overrun_clr_i(rx_overrun_clr_i),
    .data_port_rd_i(data_port_rd_i), .data_port_wr_i(data_port_wr_i), .data_port_wdata_i(data_port_wdata_i),
    .data_port_rdata_o(data_port_rdata_o), .data_port_rvalid_o(data_port_rvalid_o),
    .tx_wr_o(tx_wr_o), .tx_wdata_o(tx_wdata_o),
    .rx_ready_flag_o(rx_ready_flag_o), .rx_fifo_nonempty_flag_o(rx_fifo_nonempty_flag_o),
    .rx_overrun_flag_o(rx_overrun_flag_o), .rx_interrupt_o(rx_interrupt_o),
    .rx_reset_n_bit_o(rx_reset_n_bit_o));
  ssprx_codec ssprx_codec_inst (.rx_clk_o(rx_clk_i), .rx_frame_sync_o(rx_frame_sync_i),
    .rx_data_o(rx_serial_in_i));
  // ----
  // clock, irq counter, watchdog
  // ----
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (rx_interrupt_o === 1'h1) irqs <= irqs + 1;
  initial begin
    #500000;
    err_count++;
    end_of_test();
  end
  // ----
  // tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask
  task automatic set_rx(input logic v);
    rx_reset_n_bit_i = v;
    pulse(rx_reset_n_bit_we_i);
    cyc(2);
    `CHK(rx_reset_n_bit_o, v)
  endtask
  task automatic send_w(input logic [15:0] w, input int half);
    ssprx_codec_inst.send(w, half);
    cyc(8);
  endtask
  task automatic rd_chk(input logic [15:0] exp);
    pulse(data_port_rd_i);
    `CHK(data_port_rvalid_o, 1'h1)
    `CHK(data_port_rdata_o, exp)
    cyc(1);
  endtask
  task automatic end_of_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    reset_n_i = 1'h0;
    {rx_reset_n_bit_i, rx_reset_n_bit_we_i, rx_irq_level_hi_bit_i, rx_irq_level_lo_bit_i} = 4'h0;
    {rx_use_fifo_i, rx_overrun_clr_i, data_port_rd_i, data_port_wr_i} = 4'h0;
    data_port_wdata_i = 16'h0000;
    cyc(20);
    reset_n_i = 1'h1;
    cyc(3);
    `CHK(rx_reset_n_bit_o, 1'h0)
    set_rx(1'h1);
    // register mode: one word, ready, irq, read clears ready
    irq_mark = irqs;
    send_w(16'ha5c3, 100);
    `CHK(rx_ready_flag_o, 1'h1)
    `CHK(irqs - irq_mark, 1)
    rd_chk(16'ha5c3);
    cyc(2);
    `CHK(rx_ready_flag_o, 1'h0)
    // two words unread: overrun, clear, then receiver reset
    send_w(16'h1111, 150);
    send_w(16'h2222, 150);
    `CHK(rx_overrun_flag_o, 1'h1)
    pulse(rx_overrun_clr_i);
    cyc(3);
    `CHK(rx_overrun_flag_o, 1'h0)
    set_rx(1'h0);
    cyc(2);
    `CHK(rx_ready_flag_o, 1'h0)
    set_rx(1'h1);
    // write goes to transmit side
    data_port_wdata_i = 16'h3c5a;
    pulse(data_port_wr_i);
    `CHK(tx_wr_o, 1'h1)
    `CHK(tx_wdata_o, 16'h3c5a)
    // fifo mode: every irq level, then drain
    rx_use_fifo_i = 1'h1;
    for (int i = 0; i < 4; i++) begin
      {rx_irq_level_hi_bit_i, rx_irq_level_lo_bit_i} = i[1:0];
      irq_mark = irqs;
      for (int j = 0; j < i; j++) send_w({i[7:0], j[7:0]}, 100);
      `CHK(irqs - irq_mark, 0)
      send_w({i[7:0], i[7:0]}, 100);
      `CHK(irqs - irq_mark, 1)
      `CHK(rx_fifo_nonempty_flag_o, 1'h1)
      for (int j = 0; j <= i; j++) rd_chk({i[7:0], j[7:0]});
      cyc(3);
      `CHK(rx_fifo_nonempty_flag_o, 1'h0)
    end
    // fill past 32 words, drain part, receiver reset flushes
    for (int j = 0; j < 33; j++) send_w({8'h5a, j[7:0]}, 80);
    `CHK(rx_overrun_flag_o, 1'h1)
    for (int j = 0; j < 31; j++) rd_chk({8'h5a, j[7:0]});
    set_rx(1'h0);
    cyc(2);
    `CHK(rx_fifo_nonempty_flag_o, 1'h0)
    `CHK(rx_overrun_flag_o, 1'h0)
    end_of_test();
  end
endmodule
`default_nettype wire
